// *** hw/dhw_top.sv ***
// Debug halt, interrupt inhibit, status and coupled watchpoint logic.
// Assumes test clock, test controls, halt pin and sample clock are asynchronous.
module dhw_top (
  input  wire logic                           clk,
  input  wire logic                           rst_b,
  input  wire logic                           test_clock,
  input  wire logic                           tap_run_idle,
  input  wire logic                           dbg_update,
  input  wire logic                           dbg_write,
  input  wire dhw_pkg::dhw_sel_t              dbg_sel,
  input  wire logic [dhw_pkg::CTRL_W-1:0]     dbg_wdata,
  output logic      [dhw_pkg::CTRL_W-1:0]     dbg_rdata,
  input  wire logic                           halt_request,
  input  wire logic                           core_halt_ack,
  input  wire logic                           memory_request_low,
  input  wire logic                           instr_set_state_flag,
  input  wire logic                           debug_sample_clock,
  input  wire logic                           outside_cond_0,
  input  wire logic                           outside_cond_1,
  input  wire dhw_pkg::dhw_wp_cfg_t           wp0_cfg,
  input  wire dhw_pkg::dhw_wp_cfg_t           wp1_cfg,
  input  wire dhw_pkg::dhw_bus_t              core_bus,
  input  wire logic                           abort_taken,
  input  wire logic                           ext_abort,
  input  wire logic                           cp_write,
  input  wire logic [dhw_pkg::ACAUSE_W-1:0]   cp_wdata,
  output logic      [dhw_pkg::ACAUSE_W-1:0]   cp_rdata,
  output logic                                merged_halt_request,
  output logic                                halt_acknowledge,
  output logic                                core_irq_permit,
  output logic                                enter_debug,
  output logic                                debug_abort,
  output logic                                link_output,
  output logic                                span_output
);

  // ************************************************************
  // Two-stage synchroniser for the test-side inputs, halt pin and sample clock
  // ************************************************************
  logic [dhw_pkg::SYNC_W-1:0] meta_reg;
  logic [dhw_pkg::SYNC_W-1:0] sync_reg;
  logic                       tck_old_reg;
  logic                       dsc_old_reg;

  wire [dhw_pkg::SYNC_W-1:0] async_in = {test_clock, debug_sample_clock, halt_request,
                                         tap_run_idle, dbg_update, dbg_write,
                                         dbg_sel, dbg_wdata};

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_reg    <= '0;
      sync_reg    <= '0;
      tck_old_reg <= 1'b0;
      dsc_old_reg <= 1'b0;
    end else begin
      meta_reg    <= async_in;
      sync_reg    <= meta_reg;
      tck_old_reg <= sync_reg[12];
      dsc_old_reg <= sync_reg[11];
    end
  end

  wire                        tck_s    = sync_reg[12];
  wire                        dsc_s    = sync_reg[11];
  wire                        hreq_s   = sync_reg[10];
  wire                        idle_s   = sync_reg[9];
  wire                        upd_s    = sync_reg[8];
  wire                        wr_s     = sync_reg[7];
  wire                        sel_s    = sync_reg[6];
  wire [dhw_pkg::CTRL_W-1:0]  wdata_s  = sync_reg[5:0];
  wire                        tck_rise = tck_s & ~tck_old_reg;
  wire                        dsc_fall = ~dsc_s & dsc_old_reg;

  // ************************************************************
  // Debug control register and test-side access
  // ************************************************************
  logic [dhw_pkg::CTRL_W-1:0] ctrl_reg;
  logic [dhw_pkg::CTRL_W-1:0] ctrl_next;
  logic                       cmp_dis_reg;
  logic                       halt_latch_reg;
  logic                       mreq_tck_reg;
  logic [dhw_pkg::CTRL_W-1:0] rdata_next;

  wire access   = tck_rise & upd_s;
  wire wr_ctrl  = access & wr_s & (sel_s == dhw_pkg::DHW_SEL_CTRL);
  wire rd_acc   = access & ~wr_s;

  always_comb begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = wdata_s;
      ctrl_next[dhw_pkg::CTL_SBZ] = 1'b0;
    end
  end

  // Readback of the disable bit is the copy the comparators use
  wire [dhw_pkg::CTRL_W-1:0] ctrl_view = {cmp_dis_reg, ctrl_reg[dhw_pkg::CTL_MONITOR],
                                          1'b0, ctrl_reg[dhw_pkg::CTL_IRQ_BLK:0]};

  wire [dhw_pkg::STAT_W-1:0] stat_view = {instr_set_state_flag, mreq_tck_reg,
                                          core_irq_permit, merged_halt_request,
                                          halt_acknowledge};

  always_comb begin
    rdata_next = dbg_rdata;
    if (rd_acc) begin
      if (sel_s == dhw_pkg::DHW_SEL_CTRL) begin
        rdata_next = ctrl_view;
      end else begin
        rdata_next = {1'b0, stat_view};
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_reg     <= dhw_pkg::CTRL_RST;
      cmp_dis_reg  <= 1'b0;
      mreq_tck_reg <= 1'b0;
      dbg_rdata    <= '0;
    end else begin
      ctrl_reg     <= ctrl_next;
      cmp_dis_reg  <= ctrl_reg[dhw_pkg::CTL_CMP_DIS];
      mreq_tck_reg <= tck_rise ? memory_request_low : mreq_tck_reg;
      dbg_rdata    <= rdata_next;
    end
  end

  // ************************************************************
  // Halt request, acknowledge and interrupt permit
  // ************************************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      halt_latch_reg      <= 1'b0;
      merged_halt_request <= 1'b0;
      halt_acknowledge    <= 1'b0;
      core_irq_permit     <= 1'b0;
    end else begin
      if (idle_s) begin
        halt_latch_reg <= ctrl_reg[dhw_pkg::CTL_HALT_RQ];
      end
      merged_halt_request <= halt_latch_reg | hreq_s;
      halt_acknowledge    <= core_halt_ack | ctrl_reg[dhw_pkg::CTL_ACK_FRC];
      core_irq_permit     <= ~(core_halt_ack | ctrl_reg[dhw_pkg::CTL_ACK_FRC])
                             & ~ctrl_reg[dhw_pkg::CTL_IRQ_BLK];
    end
  end

  // ************************************************************
  // Outside conditions
  // ************************************************************
  logic       cond0_reg;
  logic       cond1_reg;
  logic [1:0] cond_meta_reg;
  logic [1:0] cond_sync_reg;

  // Same two-stage delay as the sample clock, so the fall sees aligned values
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond_meta_reg <= '0;
      cond_sync_reg <= '0;
    end else begin
      cond_meta_reg <= {outside_cond_1, outside_cond_0};
      cond_sync_reg <= cond_meta_reg;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cond0_reg <= 1'b0;
      cond1_reg <= 1'b0;
    end else if (dsc_fall) begin
      cond0_reg <= cond_sync_reg[0];
      cond1_reg <= cond_sync_reg[1];
    end
  end

  // ************************************************************
  // Watchpoint units and coupling
  // ************************************************************
  logic wp0_am;
  logic wp0_dm;
  logic wp1_am;
  logic wp1_dm;
  logic link_reg;

  dhw_wp_cmp u_wp0 (
    .cfg        (wp0_cfg),
    .bus        (core_bus),
    .addr_match (wp0_am),
    .data_match (wp0_dm)
  );

  dhw_wp_cmp u_wp1 (
    .cfg        (wp1_cfg),
    .bus        (core_bus),
    .addr_match (wp1_am),
    .data_match (wp1_dm)
  );

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      link_reg <= 1'b0;
    end else if (wp1_am) begin
      link_reg <= wp1_dm;
    end
  end

  wire span1 = wp1_am & wp1_dm;

  wire link_ok0 = ~wp0_cfg.link_care | (link_reg == wp0_cfg.link_val);
  wire span_ok0 = ~wp0_cfg.span_care | (span1 == wp0_cfg.span_val);
  wire cond_ok0 = ~wp0_cfg.cond_care | (cond0_reg == wp0_cfg.cond_val);
  wire cond_ok1 = ~wp1_cfg.cond_care | (cond1_reg == wp1_cfg.cond_val);

  wire hit0 = wp0_cfg.enable & wp0_am & wp0_dm & link_ok0 & span_ok0 & cond_ok0;
  wire hit1 = wp1_cfg.enable & wp1_am & wp1_dm & cond_ok1;
  wire hit  = (hit0 | hit1) & ~cmp_dis_reg;
  wire mon  = ctrl_reg[dhw_pkg::CTL_MONITOR];

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      enter_debug <= 1'b0;
      debug_abort <= 1'b0;
      link_output <= 1'b0;
      span_output <= 1'b0;
    end else begin
      enter_debug <= hit & ~mon;
      debug_abort <= hit & mon;
      link_output <= link_reg & ~cmp_dis_reg;
      span_output <= span1 & ~cmp_dis_reg;
    end
  end

  // ************************************************************
  // Abort cause register
  // ************************************************************
  logic cause_reg;

  wire cause_set = abort_taken & debug_abort & ~ext_abort;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cause_reg <= dhw_pkg::ACAUSE_RST[dhw_pkg::ACAUSE_BIT];
    end else if (cause_set) begin
      cause_reg <= 1'b1;
    end else if (cp_write) begin
      cause_reg <= cp_wdata[dhw_pkg::ACAUSE_BIT];
    end
  end

  assign cp_rdata = {{(dhw_pkg::ACAUSE_W-1){1'b0}}, cause_reg};

endmodule

// *** shared/dhw_pkg.sv ***
// Constants, field positions and carrier types of the debug halt and watch block.
// Assumes one core clock; test-side and sample-clock signals arrive asynchronously.
package dhw_pkg;

  // ************************************************************
  // Widths
  // ************************************************************
  localparam int ADDR_W   = 32;
  localparam int DATA_W   = 32;
  localparam int CTRL_W   = 6;
  localparam int STAT_W   = 5;
  localparam int CBUS_W   = 8;
  localparam int ACAUSE_W = 32;
  localparam int SYNC_W   = 13;

  // ************************************************************
  // Debug control bit positions
  // ************************************************************
  localparam int CTL_CMP_DIS = 5;
  localparam int CTL_MONITOR = 4;
  localparam int CTL_SBZ     = 3;
  localparam int CTL_IRQ_BLK = 2;
  localparam int CTL_HALT_RQ = 1;
  localparam int CTL_ACK_FRC = 0;

  // ************************************************************
  // Debug status bit positions
  // ************************************************************
  localparam int STA_ISET   = 4;
  localparam int STA_MREQ   = 3;
  localparam int STA_PERMIT = 2;
  localparam int STA_HALTRQ = 1;
  localparam int STA_ACK    = 0;

  // ************************************************************
  // Control bus split and abort cause
  // ************************************************************
  localparam int CB_ADDR_HI = 4;
  localparam int CB_DATA_LO = 5;
  localparam int CB_DATA_HI = 7;
  localparam int ACAUSE_BIT = 0;

  localparam logic [CTRL_W-1:0]   CTRL_RST   = 6'h00;
  localparam logic [ACAUSE_W-1:0] ACAUSE_RST = 32'h0000_0000;

  // Debugger register select
  typedef enum logic {DHW_SEL_CTRL, DHW_SEL_STAT} dhw_sel_t;

  // One watchpoint unit's programmed values
  typedef struct packed {
    logic [ADDR_W-1:0] addr_val;
    logic [ADDR_W-1:0] addr_mask;
    logic [DATA_W-1:0] data_val;
    logic [DATA_W-1:0] data_mask;
    logic [CBUS_W-1:0] ctl_val;
    logic [CBUS_W-1:0] ctl_mask;
    logic              enable;
    logic              link_care;
    logic              link_val;
    logic              span_care;
    logic              span_val;
    logic              cond_care;
    logic              cond_val;
  } dhw_wp_cfg_t;

  // Core bus observed by the comparators
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic [CBUS_W-1:0] ctl;
  } dhw_bus_t;

endpackage

// *** hw/dhw_wp_cmp.sv ***
// Masked address and data comparator of one watchpoint unit.
// Assumes configuration and bus come from the core clock domain.
module dhw_wp_cmp (
  input  dhw_pkg::dhw_wp_cfg_t cfg,
  input  dhw_pkg::dhw_bus_t    bus,
  output logic                 addr_match,
  output logic                 data_match
);

  // ************************************************************
  // Masked compare, a set mask bit always matches
  // ************************************************************
  wire [dhw_pkg::ADDR_W-1:0] a_ok = ~(cfg.addr_val ^ bus.addr) | cfg.addr_mask;
  wire [dhw_pkg::DATA_W-1:0] d_ok = ~(cfg.data_val ^ bus.data) | cfg.data_mask;
  wire [dhw_pkg::CBUS_W-1:0] c_ok = ~(cfg.ctl_val ^ bus.ctl) | cfg.ctl_mask;

  assign addr_match = (&a_ok) & (&c_ok[dhw_pkg::CB_ADDR_HI:0]);
  assign data_match = (&d_ok) & (&c_ok[dhw_pkg::CB_DATA_HI:dhw_pkg::CB_DATA_LO]);

endmodule

// *** sim/dhw_top_checker.sv ***
// Port assertions of the debug halt and watch block.
// Assumes it is bound onto dhw_top; one clock domain.
module dhw_top_checker (
  input wire logic                         clk,
  input wire logic                         rst_b,
  input wire logic                         halt_request,
  input wire logic                         core_halt_ack,
  input wire dhw_pkg::dhw_wp_cfg_t         wp1_cfg,
  input wire dhw_pkg::dhw_bus_t            core_bus,
  input wire logic                         abort_taken,
  input wire logic                         ext_abort,
  input wire logic                         cp_write,
  input wire logic [dhw_pkg::ACAUSE_W-1:0] cp_rdata,
  input wire logic                         merged_halt_request,
  input wire logic                         halt_acknowledge,
  input wire logic                         core_irq_permit,
  input wire logic                         enter_debug,
  input wire logic                         debug_abort,
  input wire logic                         span_output
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ****
  // Assertions
  // ****
  chk_permit_low: assert property (halt_acknowledge |-> !core_irq_permit)
    else $error("permit high while acknowledged");
  chk_ack_core: assert property (core_halt_ack |=> halt_acknowledge)
    else $error("core acknowledge not passed out");
  chk_pin_halt: assert property (halt_request [*4] |-> merged_halt_request)
    else $error("pin halt request not merged");
  chk_hit_excl: assert property (!(enter_debug && debug_abort))
    else $error("debug entry and abort together");
  chk_span_addr: assert property (span_output |->
    $past(((core_bus.addr ^ wp1_cfg.addr_val) & ~wp1_cfg.addr_mask) == 32'h0))
    else $error("span without address match");
  chk_abort_set: assert property (debug_abort && abort_taken && !ext_abort |=> cp_rdata[0])
    else $error("cause flag not set");
  chk_ext_wins: assert property (!cp_rdata[0] && abort_taken && ext_abort && !cp_write
    |=> !cp_rdata[0])
    else $error("cause flag set on external abort");
  chk_flag_sticky: assert property (cp_rdata[0] && !cp_write |=> cp_rdata[0])
    else $error("cause flag lost");
  chk_rsvd_zero: assert property (cp_rdata[31:1] == 31'h0)
    else $error("unused cause bits not zero");
  cover property (enter_debug);
  cover property (debug_abort);
  cover property (span_output);
endmodule
bind dhw_top dhw_top_checker u_chk (.clk(clk), .rst_b(rst_b), .halt_request(halt_request),
  .core_halt_ack(core_halt_ack), .wp1_cfg(wp1_cfg), .core_bus(core_bus),
  .abort_taken(abort_taken), .ext_abort(ext_abort), .cp_write(cp_write), .cp_rdata(cp_rdata),
  .merged_halt_request(merged_halt_request), .halt_acknowledge(halt_acknowledge),
  .core_irq_permit(core_irq_permit), .enter_debug(enter_debug), .debug_abort(debug_abort),
  .span_output(span_output));

// *** sim/dhw_core_model.sv ***
// Processor core stand-in: halt acknowledge and abort taking.
// Assumes the block's clock and reset; slow lengthens the acknowledge delay.
module dhw_core_model (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic slow,
  input  wire logic merged_halt_request,
  input  wire logic debug_abort,
  output logic      core_halt_ack,
  output logic      abort_taken
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ack_reg;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) ack_reg <= 4'h0;
    else ack_reg <= {ack_reg[2:0], merged_halt_request};
  end
  assign core_halt_ack = slow ? ack_reg[3] : ack_reg[0];
  assign abort_taken   = debug_abort;
endmodule

// *** sim/tb_debug_halt_and_watch_coupling.sv ***
// Self-checking bench for the debug halt and watch block.
// Assumes dhw_top, the core model and the bound checker.
module tb_debug_halt_and_watch_coupling;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b, test_clock, tap_run_idle, dbg_update, dbg_write, halt_request, slow;
  logic core_halt_ack, memory_request_low, instr_set_state_flag, debug_sample_clock;
  logic outside_cond_0, outside_cond_1, abort_taken, ext_abort, cp_write;
  logic merged_halt_request, halt_acknowledge, core_irq_permit, enter_debug, debug_abort;
  logic link_output, span_output;
  dhw_pkg::dhw_sel_t    dbg_sel;
  logic [5:0]           dbg_wdata, dbg_rdata, rd;
  logic [31:0]          cp_wdata, cp_rdata;
  dhw_pkg::dhw_wp_cfg_t wp0_cfg, wp1_cfg;
  dhw_pkg::dhw_bus_t    core_bus;
  int                   n_fail, checked;
  logic [31:0]          ta[4] = '{32'h40, 32'h10, 32'h40, 32'h10};
  logic [31:0]          td[4] = '{32'h5a, 32'h5a, 32'h0, 32'h0};
  logic [2:0]           te[4] = '{3'b001, 3'b110, 3'b011, 3'b001};
  dhw_top DUT (.clk, .rst_b, .test_clock, .tap_run_idle, .dbg_update, .dbg_write, .dbg_sel,
    .dbg_wdata, .dbg_rdata, .halt_request, .core_halt_ack, .memory_request_low,
    .instr_set_state_flag, .debug_sample_clock, .outside_cond_0, .outside_cond_1, .wp0_cfg,
    .wp1_cfg, .core_bus, .abort_taken, .ext_abort, .cp_write, .cp_wdata, .cp_rdata,
    .merged_halt_request, .halt_acknowledge, .core_irq_permit, .enter_debug, .debug_abort,
    .link_output, .span_output);
  dhw_core_model u_core (.clk, .rst_b, .slow, .merged_halt_request, .debug_abort,
    .core_halt_ack, .abort_taken);
  // ****
  // Tasks
  // ****
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      n_fail++;
    end
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d fails=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic acc(input logic w, input dhw_pkg::dhw_sel_t s, input logic [5:0] d);
    dbg_update = 1'b1;
    dbg_write = w;
    dbg_sel = s;
    dbg_wdata = d;
    cyc(4);
    test_clock = 1'b1;
    cyc(3);
    test_clock = 1'b0;
    dbg_update = 1'b0;
    rd = dbg_rdata;
    cyc(1);
  endtask
  task automatic poll(input logic want);
    for (int i = 0; i < 8 && rd[5] !== want; i++) acc(1'b0, dhw_pkg::DHW_SEL_CTRL, 6'h00);
    chk(rd[5], want);
    if (rd[5] !== want) tally_and_finish();
  endtask
  // ****
  // Sequence
  // ****
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    {rst_b, test_clock, tap_run_idle, dbg_update, dbg_write, halt_request, slow} = '0;
    {debug_sample_clock, outside_cond_0, outside_cond_1, ext_abort, cp_write} = '0;
    {memory_request_low, instr_set_state_flag} = 2'b11;
    dbg_sel = dhw_pkg::DHW_SEL_CTRL;
    {dbg_wdata, rd, cp_wdata, n_fail, checked} = '0;
    wp1_cfg = '0;
    wp1_cfg.addr_mask = 32'h1f;
    wp1_cfg.data_val = 32'h5a;
    wp1_cfg.ctl_mask = 8'hff;
    wp0_cfg = '0;
    wp0_cfg.addr_mask = 32'hff;
    wp0_cfg.data_mask = 32'hffff_ffff;
    wp0_cfg.ctl_mask = 8'hff;
    {wp0_cfg.enable, wp0_cfg.span_care} = 2'b11;
    core_bus = '0;
    core_bus.addr = 32'h1000;
    cyc(3);
    rst_b = 1'b1;
    cyc(6);
    acc(1'b0, dhw_pkg::DHW_SEL_CTRL, 6'h00);
    chk(rd, 6'h00);
    chk(cp_rdata, 32'h0);
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h0f);
    cyc(4);
    chk({merged_halt_request, halt_acknowledge, core_irq_permit}, 3'b010);
    acc(1'b0, dhw_pkg::DHW_SEL_CTRL, 6'h00);
    chk(rd, 6'h07);
    acc(1'b1, dhw_pkg::DHW_SEL_STAT, 6'h00);
    acc(1'b0, dhw_pkg::DHW_SEL_STAT, 6'h00);
    chk(rd, 6'h19);
    tap_run_idle = 1'b1;
    cyc(8);
    chk(merged_halt_request, 1'b1);
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h00);
    cyc(10);
    chk({merged_halt_request, halt_acknowledge, core_irq_permit}, 3'b001);
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h04);
    cyc(2);
    chk({merged_halt_request, halt_acknowledge, core_irq_permit}, 3'b000);
    slow = 1'b1;
    halt_request = 1'b1;
    cyc(12);
    chk({merged_halt_request, halt_acknowledge, core_irq_permit}, 3'b110);
    halt_request = 1'b0;
    cyc(12);
    for (int k = 0; k < 4; k++) begin
      core_bus.addr = ta[k];
      core_bus.data = td[k];
      cyc(2);
      chk({span_output, link_output, enter_debug}, te[k]);
    end
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h20);
    poll(1'b1);
    core_bus.data = 32'h5a;
    cyc(2);
    chk({span_output, link_output, enter_debug}, 3'b000);
    core_bus.addr = 32'h40;
    cyc(2);
    chk({span_output, link_output, enter_debug}, 3'b000);
    core_bus.addr = 32'h1000;
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h30);
    acc(1'b1, dhw_pkg::DHW_SEL_CTRL, 6'h10);
    poll(1'b0);
    core_bus.addr = 32'h40;
    cyc(2);
    chk({enter_debug, debug_abort}, 2'b01);
    cyc(2);
    chk(cp_rdata, 32'h1);
    core_bus.addr = 32'h1000;
    cyc(4);
    chk(cp_rdata, 32'h1);
    cp_write = 1'b1;
    cyc(1);
    cp_write = 1'b0;
    cyc(1);
    chk(cp_rdata, 32'h0);
    ext_abort = 1'b1;
    core_bus.addr = 32'h40;
    cyc(4);
    chk(cp_rdata, 32'h0);
    ext_abort = 1'b0;
    wp0_cfg.cond_care = 1'b1;
    wp0_cfg.cond_val = 1'b1;
    outside_cond_0 = 1'b1;
    debug_sample_clock = 1'b1;
    cyc(4);
    chk(debug_abort, 1'b0);
    debug_sample_clock = 1'b0;
    cyc(6);
    chk(debug_abort, 1'b1);
    tally_and_finish();
  end
endmodule
